// File: common/vme_dram_pkg.sv
package vme_dram_pkg;

    // clock and timing
    localparam int CLK_NS           = 4;
    localparam int DATA_SETUP_NS    = 28;
    localparam int DATA_SETUP_CYC   = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DATA_HOLD_NS     = 10;
    localparam int DATA_HOLD_CYC    = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int REFRESH_NS       = 16000;
    localparam int REFRESH_CYC      = REFRESH_NS / CLK_NS;
    localparam int REFRESH_BUSY_NS  = 200;
    localparam int REFRESH_BUSY_CYC = REFRESH_BUSY_NS / CLK_NS;

    // organisation
    localparam int NUM_BLOCKS  = 4;
    localparam int AM_ENTRIES  = 256;
    localparam int SMALL_SHIFT = 14;
    localparam int LARGE_SHIFT = 16;

    // register byte offsets
    localparam logic [11:0] BASE0_OFS  = 12'h000;
    localparam logic [11:0] CTRL_OFS   = 12'h010;
    localparam logic [11:0] STATUS_OFS = 12'h014;
    localparam logic [11:0] AMTAB_OFS  = 12'h400;

    // field positions
    localparam int BLK_EN_BIT     = 0;
    localparam int CTRL_BERR_OFF  = 0;
    localparam int CTRL_REF_OFF   = 1;
    localparam int CTRL_FORCE_LSB = 2;
    localparam int ST_IND_BIT     = 0;
    localparam int ST_BUSY_BIT    = 1;
    localparam int ST_REF_BIT     = 2;

    // parity force bits: low byte to 0 / 1, high byte to 0 / 1
    localparam int FRC_LO0 = 0;
    localparam int FRC_LO1 = 1;
    localparam int FRC_HI0 = 2;
    localparam int FRC_HI1 = 3;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0]  AM_RST   = 4'hF;

endpackage

// File: common/mem_if.sv
`timescale 1ns/1ps
`default_nettype none

// request / answer path between access control and parity memory
interface mem_if #(parameter int AW = 15);
    logic          req;
    logic          we;
    logic [1:0]    be;
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic [3:0]    force_par;
    logic [15:0]   rdata;
    logic [1:0]    perr;
    logic          done;

    modport ctrl (output req, we, be, addr, wdata, force_par,
                  input  rdata, perr, done);
    modport mem  (input  req, we, be, addr, wdata, force_par,
                  output rdata, perr, done);
endinterface

`default_nettype wire

// File: core/am_select.sv
`timescale 1ns/1ps
`default_nettype none

module am_select
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // table write and read-back
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_idx,
    input  wire logic [3:0] wr_val,
    input  wire logic [7:0] rd_idx,
    output logic      [3:0] rd_val,
    // lookup
    input  wire logic [7:0] code,
    input  wire logic       strobe,
    output logic      [3:0] sel
);
    logic [3:0] table_r [0:vme_dram_pkg::AM_ENTRIES-1];

    // replaceable contents, every code enabled after reset
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            for (int i = 0; i < vme_dram_pkg::AM_ENTRIES; i++)
                table_r[i] <= vme_dram_pkg::AM_RST;
        end
        else if (wr_en)
            table_r[wr_idx] <= wr_val;

    assign rd_val = table_r[rd_idx];

    // selects only move on the local strobe
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sel <= 4'h0;
        else if (strobe)
            sel <= table_r[code];
endmodule

`default_nettype wire

// File: core/parity_ram.sv
`timescale 1ns/1ps
`default_nettype none

module parity_ram #(parameter int AW = 15)
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // access port
    mem_if.mem        m
);
    // bit 17 high-byte parity, bit 16 low-byte parity
    logic [17:0] store_r [0:(2**AW)-1];

    function automatic logic odd_par(input logic [7:0] b);
        return ~^b;
    endfunction

    // write with odd parity, optionally forced for testing
    always_ff @(posedge pclk)
        if (m.req && m.we)
        begin
            if (m.be[0])
            begin
                store_r[m.addr][7:0] <= m.wdata[7:0];
                store_r[m.addr][16]  <=
                    m.force_par[vme_dram_pkg::FRC_LO1] ? 1'b1 :
                    m.force_par[vme_dram_pkg::FRC_LO0] ? 1'b0 :
                    odd_par(m.wdata[7:0]);
            end
            if (m.be[1])
            begin
                store_r[m.addr][15:8] <= m.wdata[15:8];
                store_r[m.addr][17]   <=
                    m.force_par[vme_dram_pkg::FRC_HI1] ? 1'b1 :
                    m.force_par[vme_dram_pkg::FRC_HI0] ? 1'b0 :
                    odd_par(m.wdata[15:8]);
            end
        end

    // read and recheck each strobed byte
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            m.rdata <= 16'h0000;
            m.perr  <= 2'h0;
            m.done  <= 1'b0;
        end
        else
        begin
            m.done <= m.req;
            if (m.req && !m.we)
            begin
                m.rdata   <= store_r[m.addr][15:0];
                m.perr[0] <= m.be[0] &&
                    (odd_par(store_r[m.addr][7:0]) != store_r[m.addr][16]);
                m.perr[1] <= m.be[1] &&
                    (odd_par(store_r[m.addr][15:8]) != store_r[m.addr][17]);
            end
        end
endmodule

`default_nettype wire

// File: core/vme_dram_slave.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module vme_dram_slave #(parameter int BLOCK_SHIFT = vme_dram_pkg::SMALL_SHIFT)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // register bus
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // memory bus inputs
    input  wire logic [23:1] vme_addr,
    input  wire logic        vme_lword_n,
    input  wire logic [5:0]  vme_am,
    input  wire logic        vme_iack_n,
    input  wire logic        vme_write_n,
    input  wire logic        vme_ds0_n,
    input  wire logic        vme_ds1_n,
    input  wire logic [15:0] vme_data_in,
    // memory bus outputs
    output logic      [15:0] vme_data_out,
    output logic             vme_data_oe,
    output logic             dtack_n_out,
    output logic             dtack_n_oe,
    output logic             berr_n_out,
    output logic             berr_n_oe,
    // status
    output logic             parity_fault_n,
    output logic             parity_led,
    output logic             busy_led
);
    localparam int WAW = BLOCK_SHIFT + 1;
    localparam int SYNC_W = 50;
    localparam int SETUP = vme_dram_pkg::DATA_SETUP_CYC;
    localparam int HOLD = vme_dram_pkg::DATA_HOLD_CYC;
    localparam int REF_CYC = vme_dram_pkg::REFRESH_CYC;
    localparam int REF_BUSY = vme_dram_pkg::REFRESH_BUSY_CYC;

    typedef enum logic [2:0] {
        ST_IDLE, ST_REFRESH, ST_DECODE, ST_ACCESS,
        ST_SETUP, ST_ACK, ST_HOLD, ST_IGNORE
    } state_e;

    state_e              st_r;
    logic [SYNC_W-1:0]   sync1_r;
    logic [SYNC_W-1:0]   sync2_r;
    logic [23:1]         s_addr;
    logic                s_lword_n;
    logic [5:0]          s_am;
    logic                s_iack_n;
    logic                s_write_n;
    logic                s_ds0_n;
    logic                s_ds1_n;
    logic [15:0]         s_data;
    logic                ds_any;
    logic                strobe;
    logic [23:1]         addr_r;
    logic                lword_n_r;
    logic                we_r;
    logic [1:0]          be_r;
    logic [3:0]          am_sel;
    logic [3:0]          am_rd;
    logic [23:BLOCK_SHIFT] base_r [0:vme_dram_pkg::NUM_BLOCKS-1];
    logic [vme_dram_pkg::NUM_BLOCKS-1:0] en_r;
    logic [31:0]         ctrl_r;
    logic                hit;
    logic [1:0]          hit_blk;
    logic [15:0]         cnt_r;
    logic [12:0]         ref_tmr_r;
    logic                ref_pend_r;
    logic                berr_sel_r;
    logic                ind_r;
    logic                fault_r;
    logic                rd_done;
    logic                rd_err;
    logic                berr_off;
    logic                dtack_act;
    logic                berr_act;
    logic [31:0]         rd_val;
    logic                apb_wr;
    logic                is_am;
    logic                mapped;

    mem_if #(.AW(WAW)) mbus ();

    // two flip-flops on every bus input before any logic
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sync1_r <= {SYNC_W{1'b1}};
            sync2_r <= {SYNC_W{1'b1}};
        end
        else
        begin
            sync1_r <= {vme_addr, vme_lword_n, vme_am, vme_iack_n,
                        vme_write_n, vme_ds0_n, vme_ds1_n, vme_data_in};
            sync2_r <= sync1_r;
        end

    assign {s_addr, s_lword_n, s_am, s_iack_n, s_write_n,
            s_ds0_n, s_ds1_n, s_data} = sync2_r;
    assign ds_any = !s_ds0_n || !s_ds1_n;
    assign berr_off = ctrl_r[vme_dram_pkg::CTRL_BERR_OFF];

    // local strobe: access start seen in idle with no refresh due
    assign strobe = (st_r == ST_IDLE) && ds_any && !ref_pend_r;

    // capture address, size, direction and byte lanes
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            addr_r    <= 23'h000000;
            lword_n_r <= 1'b1;
            we_r      <= 1'b0;
            be_r      <= 2'h0;
        end
        else if (strobe)
        begin
            addr_r    <= s_addr;
            lword_n_r <= s_lword_n;
            we_r      <= !s_write_n;
            be_r      <= {!s_ds1_n, !s_ds0_n};
        end

    am_select u_am (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (apb_wr && is_am),
        .wr_idx  (paddr[9:2]),
        .wr_val  (pwdata[3:0]),
        .rd_idx  (paddr[9:2]),
        .rd_val  (am_rd),
        .code    ({s_lword_n, s_iack_n, s_am}),
        .strobe  (strobe),
        .sel     (am_sel)
    );

    // block match: enabled, base equal, modifier select on
    always_comb
    begin
        hit     = 1'b0;
        hit_blk = 2'h0;
        for (int i = 0; i < vme_dram_pkg::NUM_BLOCKS; i++)
            if (en_r[i] && am_sel[i] && base_r[i] == addr_r[23:BLOCK_SHIFT])
            begin
                hit     = 1'b1;
                hit_blk = i[1:0];
            end
    end

    // memory request issued once per decoded hit
    assign mbus.req       = (st_r == ST_DECODE) && hit;
    assign mbus.we        = we_r;
    assign mbus.be        = be_r;
    assign mbus.addr      = {hit_blk, addr_r[BLOCK_SHIFT-1:1]};
    assign mbus.wdata     = s_data; // master still holds it
    assign mbus.force_par = ctrl_r[vme_dram_pkg::CTRL_FORCE_LSB +: 4];

    parity_ram #(.AW(WAW)) u_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .m       (mbus)
    );

    assign rd_done = (st_r == ST_ACCESS) && mbus.done && !we_r;
    assign rd_err  = rd_done && (mbus.perr != 2'h0);

    // access sequencer; refresh wins a tie, access then waits
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            st_r  <= ST_IDLE;
            cnt_r <= 16'h0000;
        end
        else
            case (st_r)
                ST_IDLE:
                    if (ref_pend_r)
                    begin
                        st_r  <= ST_REFRESH;
                        cnt_r <= 16'(REF_BUSY - 1);
                    end
                    else if (ds_any)
                        st_r <= ST_DECODE;
                ST_REFRESH:
                    if (cnt_r == 16'h0000)
                        st_r <= ST_IDLE;
                    else
                        cnt_r <= cnt_r - 16'h0001;
                ST_DECODE:
                    st_r <= hit ? ST_ACCESS : ST_IGNORE;
                ST_ACCESS:
                    if (mbus.done)
                    begin
                        if (we_r || (rd_err && !berr_off))
                            st_r <= ST_ACK;
                        else
                        begin
                            st_r  <= ST_SETUP;
                            cnt_r <= 16'(SETUP - 1);
                        end
                    end
                ST_SETUP:
                    if (cnt_r == 16'h0000)
                        st_r <= ST_ACK; // data settled first
                    else
                        cnt_r <= cnt_r - 16'h0001;
                ST_ACK:
                    if (!ds_any)
                    begin
                        st_r  <= we_r ? ST_IDLE : ST_HOLD;
                        cnt_r <= 16'(HOLD - 1);
                    end
                ST_HOLD:
                    if (cnt_r == 16'h0000)
                        st_r <= ST_IDLE;
                    else
                        cnt_r <= cnt_r - 16'h0001;
                ST_IGNORE:
                    if (!ds_any)
                        st_r <= ST_IDLE;
                default:
                    st_r <= ST_IDLE;
            endcase

    // periodic refresh request, gated by the disable option
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ref_tmr_r  <= 13'h0000;
            ref_pend_r <= 1'b0;
        end
        else if (ctrl_r[vme_dram_pkg::CTRL_REF_OFF])
        begin
            ref_tmr_r  <= 13'h0000;
            ref_pend_r <= 1'b0;
        end
        else
        begin
            ref_tmr_r <= (ref_tmr_r == 13'(REF_CYC - 1)) ?
                         13'h0000 : ref_tmr_r + 13'h0001;
            if (ref_tmr_r == 13'(REF_CYC - 1))
                ref_pend_r <= 1'b1; // new tick beats the clear
            else if (st_r == ST_REFRESH)
                ref_pend_r <= 1'b0;
        end

    // read data captured from memory, only driven while enabled
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            vme_data_out <= 16'h0000;
        else if (rd_done)
            vme_data_out <= mbus.rdata;

    assign vme_data_oe = !we_r &&
        (st_r == ST_SETUP || st_r == ST_ACK || st_r == ST_HOLD);

    // error termination choice and fault level
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            berr_sel_r <= 1'b0;
            fault_r    <= 1'b0;
        end
        else if (st_r == ST_DECODE)
        begin
            berr_sel_r <= 1'b0;
            fault_r    <= 1'b0;
        end
        else if (rd_err)
        begin
            berr_sel_r <= !berr_off;
            fault_r    <= 1'b1;
        end

    // sticky indicator; with bus error on, an error wins over a clean byte
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ind_r <= 1'b0;
        else if (rd_err && !berr_off)
            ind_r <= 1'b1;
        else if (rd_done && (mbus.perr != mbus.be))
            ind_r <= 1'b0;

    // acknowledge and bus error, open collector
    assign dtack_act      = (st_r == ST_ACK) && !berr_sel_r;
    assign berr_act       = (st_r == ST_ACK) && berr_sel_r;
    assign dtack_n_out    = 1'b0;
    assign dtack_n_oe     = dtack_act;
    assign berr_n_out     = 1'b0;
    assign berr_n_oe      = berr_act;
    assign parity_fault_n = !fault_r;
    assign parity_led     = ind_r;
    assign busy_led       = st_r inside {ST_ACCESS, ST_SETUP, ST_ACK, ST_HOLD};

    // register bus decode; zero wait states
    assign is_am  = paddr[11:10] == vme_dram_pkg::AMTAB_OFS[11:10];
    assign mapped = is_am || paddr[11:4] == 8'h00 ||
                    paddr == vme_dram_pkg::CTRL_OFS ||
                    paddr == vme_dram_pkg::STATUS_OFS;
    assign apb_wr  = psel && penable && pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // block bases, enables and control settings
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            for (int i = 0; i < vme_dram_pkg::NUM_BLOCKS; i++)
                base_r[i] <= '0;
            en_r   <= '0;
            ctrl_r <= vme_dram_pkg::CTRL_RST;
        end
        else if (apb_wr && !is_am)
        begin
            if (paddr[11:4] == 8'h00)
            begin
                base_r[paddr[3:2]] <= pwdata[23:BLOCK_SHIFT];
                en_r[paddr[3:2]]   <= pwdata[vme_dram_pkg::BLK_EN_BIT];
            end
            else if (paddr == vme_dram_pkg::CTRL_OFS)
                ctrl_r <= {26'h0, pwdata[5:0]};
        end

    // read mux, status shows the block's own state
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (is_am)
            rd_val[3:0] = am_rd;
        else if (paddr[11:4] == 8'h00)
        begin
            rd_val[23:BLOCK_SHIFT] = base_r[paddr[3:2]];
            rd_val[vme_dram_pkg::BLK_EN_BIT] = en_r[paddr[3:2]];
        end
        else if (paddr == vme_dram_pkg::CTRL_OFS)
            rd_val = ctrl_r;
        else if (paddr == vme_dram_pkg::STATUS_OFS)
        begin
            rd_val[vme_dram_pkg::ST_IND_BIT]  = ind_r;
            rd_val[vme_dram_pkg::ST_BUSY_BIT] = busy_led;
            rd_val[vme_dram_pkg::ST_REF_BIT]  = st_r == ST_REFRESH;
        end
    end

    // read data registered in the setup phase, ready in the access phase
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= rd_val;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ack_exclusive_a: assert property (!(dtack_n_oe && berr_n_oe))
        else $error("dtack and berr both driven");
    read_setup_a: assert property (
        $rose(dtack_n_oe) && !we_r |-> $past(vme_data_oe, SETUP))
        else $error("read data not settled before dtack");
    read_hold_a: assert property (
        st_r == ST_ACK && !ds_any && !we_r |=> vme_data_oe [*3])
        else $error("read data dropped too early");
    perr_berr_a: assert property (
        rd_err && !berr_off |=> berr_n_oe && !parity_fault_n && parity_led)
        else $error("parity error without bus error");
    suppress_a: assert property (
        rd_err && berr_off && !ind_r |=> !parity_led ##0 !berr_n_oe [*3])
        else $error("suppressed error still flagged");
    clean_clear_a: assert property (
        rd_done && mbus.perr == 2'h0 && mbus.be != 2'h0 |=> !parity_led)
        else $error("indicator kept after clean read");
    ignore_miss_a: assert property (
        st_r == ST_DECODE && !hit |=> st_r == ST_IGNORE && !dtack_n_oe)
        else $error("answered outside enabled block");
    release_a: assert property (
        st_r == ST_ACK && !ds_any |=> !dtack_n_oe && !berr_n_oe)
        else $error("acknowledge kept after strobes released");
    refresh_hold_a: assert property (
        ref_pend_r && st_r == ST_IDLE |=> st_r == ST_REFRESH && !mbus.req)
        else $error("memory request during refresh");
    write_ack_a: assert property (
        st_r == ST_ACCESS && mbus.done && we_r |=> dtack_n_oe)
        else $error("write not acknowledged");

    write_cov: cover property (mbus.req && mbus.we ##[1:4] dtack_n_oe);
    read_cov: cover property ($rose(dtack_n_oe) && !we_r);
    berr_cov: cover property ($rose(berr_n_oe));
    refresh_cov: cover property (st_r == ST_REFRESH && ds_any);
endmodule

`default_nettype wire

// File: tb/vme_master.sv
`timescale 1ns/1ps
`default_nettype none

module vme_master
(
    // clock and slave answers
    input  wire logic        pclk,
    input  wire logic        dk,
    input  wire logic        be,
    input  wire logic [15:0] din,
    // master drive
    output logic      [23:1] addr,
    output logic             write_n,
    output logic             ds0_n,
    output logic             ds1_n,
    output logic      [15:0] dout
);
    initial {addr, write_n, ds0_n, ds1_n, dout} = {23'h0, 3'h7, 16'h0};

    // one cycle; rsp 0 none, 1 ack, 2 bus error
    task automatic cyc(input logic w, input logic [23:1] a,
        input logic [1:0] ds, input logic [15:0] wd,
        output logic [15:0] rd, output int rsp);
        int n;
        n = 0;
        @(posedge pclk);
        write_n <= ~w;
        addr <= a;
        dout <= w ? wd : ~dout;
        @(posedge pclk);
        {ds1_n, ds0_n} <= ~ds;
        while (dk !== 1'b1 && be !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        rsp = dk === 1'b1 ? 1 : (be === 1'b1 ? 2 : 0);
        rd = din;
        {ds1_n, ds0_n, write_n} <= 3'h7;
        dout <= ~dout; // data held until answer, then stale
        repeat (10) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// File: tb/vme_dram_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

module vme_dram_slave_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, se, d_oe, dk, be, led, wn, ds0, ds1, pf;
    logic [15:0] d_out, m_d, rdv;
    logic [23:1] va;
    logic [15:0] mm [int];
    bit   [1:0]  mb [int];
    bit   [3:0]  frc;
    bit          sup;
    int          bad_count, samples_checked, rsp, i;
    wire  [15:0] bus_d = d_oe ? d_out : m_d;

    always #2 pclk = ~pclk;

    vme_dram_slave dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .vme_addr(va), .vme_lword_n(1'b1), .vme_am(6'h3D),
        .vme_iack_n(1'b1), .vme_write_n(wn), .vme_ds0_n(ds0),
        .vme_ds1_n(ds1), .vme_data_in(bus_d), .vme_data_out(d_out),
        .vme_data_oe(d_oe), .dtack_n_out(), .dtack_n_oe(dk),
        .berr_n_out(), .berr_n_oe(be), .parity_fault_n(pf),
        .parity_led(led), .busy_led());
    vme_master m_u (.pclk(pclk), .dk(dk), .be(be), .din(bus_d), .addr(va),
        .write_n(wn), .ds0_n(ds0), .ds1_n(ds1), .dout(m_d));

    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            $display("wrong value %s exp %h got %h", s, e, g);
            bad_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // write; model keeps which bytes got a wrong parity bit
    task automatic bw(input logic [23:1] a, input logic [1:0] s,
        input logic [15:0] d);
        m_u.cyc(1, a, s, d, rdv, rsp);
        chk("wr ack", 1, rsp);
        mm[a] = {s[1] ? d[15:8] : mm[a][15:8], s[0] ? d[7:0] : mm[a][7:0]};
        if (s[0])
            mb[a][0] = frc[1] ? ^d[7:0] : frc[0] & ~^d[7:0];
        if (s[1])
            mb[a][1] = frc[3] ? ^d[15:8] : frc[2] & ~^d[15:8];
    endtask

    task automatic br(input logic [23:1] a);
        int e;
        e = (mb[a] != 0 && !sup) ? 2 : 1;
        m_u.cyc(0, a, 2'b11, 16'h0, rdv, rsp);
        chk("rd resp", e, rsp);
        if (e == 1)
            chk("rd data", mm[a], rdv);
        chk("led", e == 2, led);
        chk("oe off", 0, d_oe);
        chk("fault", mb[a] == 0, pf);
        apb(0, 12'h014, 0);
        chk("status", e == 2, q[0]);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence, two blocks: 0x100000 and 0x204000
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        i = $urandom(32'hAF37);
        apb(0, 12'h010, 0);
        chk("ctrl", vme_dram_pkg::CTRL_RST, q);
        apb(0, 12'h7F4, 0);
        chk("am", vme_dram_pkg::AM_RST, q);
        apb(0, 12'hFFC, 0);
        chk("unmapped", 1, se);
        m_u.cyc(1, 23'h80000, 2'b11, 16'h1234, rdv, rsp);
        chk("disabled", 0, rsp);
        apb(1, 12'h000, 32'h0010_0001);
        apb(1, 12'h004, 32'h0020_4001);
        for (i = 0; i < 8; i++)
            bw(i % 2 ? 23'h102000 + i : 23'h80000 + i, 2'b11, 16'($urandom));
        bw(23'h80002, 2'b01, 16'($urandom));
        bw(23'h80004, 2'b10, 16'($urandom));
        for (i = 0; i < 8; i++)
            br(i % 2 ? 23'h102000 + i : 23'h80000 + i);
        m_u.cyc(0, 23'h104000, 2'b11, 0, rdv, rsp);
        chk("outside", 0, rsp);
        // first refresh falls inside this run, reads must wait and stay right
        repeat (2500) @(posedge pclk);
        for (i = 0; i < 60; i++)
            br(23'h80000 + 2 * (i % 4));
        for (i = 0; i < 4; i++)
        begin
            frc = 4'h1 << i;
            apb(1, 12'h010, {26'h0, frc, 2'b00});
            bw(23'h80010, 2'b11, i % 2 ? 16'h0101 : 16'h0000);
            frc = 0;
            apb(1, 12'h010, 0);
            br(23'h80010);
            br(23'h80000);
        end
        frc = 4'h1;
        apb(1, 12'h010, 32'h0000_0004);
        bw(23'h80011, 2'b11, 16'h0000);
        frc = 0;
        sup = 1;
        apb(1, 12'h010, 32'h0000_0001);
        br(23'h80011);
        apb(1, 12'h7F4, 32'h0000_000E);
        m_u.cyc(0, 23'h80000, 2'b11, 0, rdv, rsp);
        chk("am off", 0, rsp);
        m_u.cyc(0, 23'h102001, 2'b11, 0, rdv, rsp);
        chk("am on", 1, rsp);
        apb(0, 12'h7F4, 0);
        chk("am rd", 32'hE, q);
        final_report;
    end

    // watchdog, well beyond the expected run
    initial
    begin
        #200000;
        bad_count++;
        final_report;
    end
endmodule

`default_nettype wire
